// ==== logic/itb_pkg.sv ====
/*
  Package of the interrupt and time base controller: register offsets, field
  positions, reset values, source indices and time base constants.
  Assumes a 32-bit classic Wishbone register bus and a 100 MHz system clock.
*/
package itb_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_ENABLE   = 8'h04;
  localparam logic [7:0] OFS_FLAGS    = 8'h08;
  localparam logic [7:0] OFS_PRESCALE = 8'h0c;
  localparam logic [7:0] OFS_TB0      = 8'h10;
  localparam logic [7:0] OFS_TB1      = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;

  // ----------------------------------------------------------------
  // Sources, in priority order (index 0 highest)
  // ----------------------------------------------------------------
  localparam int NUM_SRC  = 10;
  localparam int SRC_CONV = 0;
  localparam int SRC_TB0  = 1;
  localparam int SRC_TB1  = 2;
  localparam int SRC_SER  = 3;
  localparam int SRC_LOW  = 4;
  localparam int SRC_EE   = 5;
  localparam int SRC_PTMP = 6;
  localparam int SRC_PTMA = 7;
  localparam int SRC_STMP = 8;
  localparam int SRC_STMA = 9;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_GIE_BIT  = 0;
  localparam int TB_RUN_BIT    = 7;
  localparam int TB_PER_LSB    = 0;
  localparam int STAT_ANY_BIT  = 4;
  localparam int STAT_FULL_BIT = 5;
  localparam logic [9:0] RST_ENABLE   = 10'h000;
  localparam logic [9:0] RST_FLAGS    = 10'h000;
  localparam logic [1:0] RST_PRESCALE = 2'h0;
  localparam logic [7:0] RST_TBCTRL   = 8'h00;
  localparam logic       RST_GIE      = 1'b0;

  // ----------------------------------------------------------------
  // Prescaler and time base constants
  // ----------------------------------------------------------------
  localparam logic [1:0] PSC_SYS     = 2'h0;
  localparam logic [1:0] PSC_SYS_DIV = 2'h1;
  localparam int         PSC_DIV     = 4;
  localparam int         TB_MIN_EXP  = 8;
  localparam int         TB_CNT_W    = 15;

endpackage : itb_pkg

// ==== logic/itb_tick_if.sv ====
/*
  Interface between the controller and one time base unit.
  Assumes both ends run on the same system clock.
*/
interface itb_tick_if;
  logic       tick;       // Prescaled clock enable
  logic       run;        // Unit enable
  logic [2:0] periodSel;  // Period exponent offset
  logic       overflow;   // One-cycle divider overflow

  modport ctrl (output tick, output run, output periodSel, input overflow);
  modport unit (input tick, input run, input periodSel, output overflow);
endinterface : itb_tick_if

// ==== logic/itb_time_base.sv ====
/*
  One time base unit: a divider counting prescaled ticks, pulsing overflow
  after two to the power of eight plus the period code ticks.
  Assumes tick is a one-cycle enable on the system clock.
*/
module itb_time_base (
  input  wire logic clk,          // System clock
  input  wire logic rst,          // Synchronous reset, active high
  itb_tick_if.unit  tb            // Tick, run, period and overflow
);

  logic [itb_pkg::TB_CNT_W-1:0] count_r;
  logic [itb_pkg::TB_CNT_W-1:0] count_nxt;
  logic                         ovf_r;
  logic                         ovf_nxt;

  // Last count value of the selected period
  function automatic logic [itb_pkg::TB_CNT_W-1:0] periodLast(input logic [2:0] sel);
    logic [itb_pkg::TB_CNT_W:0] one;
    one = '0;
    one[itb_pkg::TB_MIN_EXP + int'(sel)] = 1'b1;
    return itb_pkg::TB_CNT_W'(one - 1'b1);
  endfunction : periodLast

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Count ticks while running, clear when stopped
  always_comb begin
    count_nxt = count_r;
    ovf_nxt   = 1'b0;
    if (!tb.run) begin
      count_nxt = '0;
    end else if (tb.tick) begin
      if (count_r >= periodLast(tb.periodSel)) begin
        count_nxt = '0;
        ovf_nxt   = 1'b1;
      end else begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  // Register divider state
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
      ovf_r   <= 1'b0;
    end else begin
      count_r <= count_nxt;
      ovf_r   <= ovf_nxt;
    end
  end

  assign tb.overflow = ovf_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_tb_stop;
    @(posedge clk) disable iff (rst) !tb.run |=> count_r == '0 && !ovf_r;
  endproperty
  a_tb_stop: assert property (p_tb_stop) else $error("time base counts while stopped");

  property p_tb_period;
    @(posedge clk) disable iff (rst)
      tb.run && tb.tick && count_r == periodLast(tb.periodSel) |=> ovf_r && count_r == '0;
  endproperty
  a_tb_period: assert property (p_tb_period) else $error("no overflow at period end");

  property p_tb_early;
    @(posedge clk) disable iff (rst) ovf_r |-> $past(count_r) == periodLast($past(tb.periodSel));
  endproperty
  a_tb_early: assert property (p_tb_early) else $error("overflow before period end");

endmodule : itb_time_base

// ==== logic/itb_irq_ctrl.sv ====
/*
  Interrupt request controller with two time base units and a prescaler,
  reached over a classic Wishbone slave with 8/16-bit registers in 32-bit words.
  Assumes event inputs are one-cycle pulses synchronous to clk, and the core
  pushes the program counter on pcPush and jumps to irqVector on irqCall.
*/
// Behaviour
// - Conversion-done pulse sets the conversion request flag.
// - Call only with global enable, source enable set and stack not full.
// - Servicing clears the chosen flag and the global enable.
// - Each time base overflow sets its own request flag.
// - Prescaler source: 00 system clock, 01 system clock/4, 1x sub clock.
// - Period is two to the eight plus code prescaled ticks.
// - Sync or two-wire serial events set the serial flag.
// - Async serial events set the serial flag.
// - Servicing serial never clears the async unit's own status.
// - Low supply report sets the low supply flag.
// - EEPROM write finish sets the EEPROM flag.
// - Each timer has separate P and A match flags, enables, vectors.
// - Any flag rising wakes the device, whatever the enables.
// - A set flag stays until serviced or cleared by software.
// - Only the program counter is pushed when servicing.
// - Interrupt return restores PC and sets global enable; plain return doesn't.
// - Requests during cleared global enable are still latched.
module itb_irq_ctrl (
  input  wire logic        clk,             // System clock, 100 MHz
  input  wire logic        rst,             // Synchronous reset, active high
  input  wire logic        wb_cyc_i,        // Wishbone cycle
  input  wire logic        wb_stb_i,        // Wishbone strobe
  input  wire logic        wb_we_i,         // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,        // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,        // Wishbone byte enables
  input  wire logic [31:0] wb_dat_i,        // Wishbone write data
  output logic      [31:0] wb_dat_o,        // Wishbone read data
  output logic             wb_ack_o,        // Wishbone acknowledge
  input  wire logic        convDone,        // Conversion finished pulse
  input  wire logic        serialAsyncMode, // Serial module in async mode
  input  wire logic        syncByteDone,    // Sync byte sent or received
  input  wire logic        syncAddrMatch,   // Two-wire slave address match
  input  wire logic        syncBusTimeout,  // Two-wire bus time-out
  input  wire logic        asyncTxEmpty,    // Async transmit register empty
  input  wire logic        asyncTxIdle,     // Async transmitter idle
  input  wire logic        asyncRxAvail,    // Async receive data available
  input  wire logic        asyncOverrun,    // Async receive overrun
  input  wire logic        asyncAddrDetect, // Async address detect
  input  wire logic        asyncRxWake,     // Async receive pin wake-up
  input  wire logic        lowSupply,       // Low supply detector report pulse
  input  wire logic        eepromWriteDone, // EEPROM write cycle finished
  input  wire logic        ptmPMatch,       // Periodic timer P match
  input  wire logic        ptmAMatch,       // Periodic timer A match
  input  wire logic        stmPMatch,       // Standard timer P match
  input  wire logic        stmAMatch,       // Standard timer A match
  input  wire logic        subClkTick,      // Slow sub clock enable pulse
  input  wire logic        stackFull,       // Core return stack full
  input  wire logic        retStrobe,       // Core executes plain return
  input  wire logic        retiStrobe,      // Core executes interrupt return
  output logic             irqCall,         // Vector call pulse to core
  output logic      [3:0]  irqVector,       // Source index of the call
  output logic             pcPush,          // Push program counter only
  output logic             wakeUp           // Wake from sleep or idle pulse
);

  localparam int N = itb_pkg::NUM_SRC;

  logic          gie_r,    gie_nxt;
  logic [N-1:0]  enable_r, enable_nxt;
  logic [N-1:0]  flags_r,  flags_nxt;
  logic [1:0]    psc_r,    psc_nxt;
  logic [7:0]    time_base_0_control_r,   time_base_0_control_nxt;
  logic [7:0]    time_base_1_control_r,   time_base_1_control_nxt;
  logic [1:0]    div_r,    div_nxt;
  logic          ack_r,    ack_nxt;
  logic [31:0]   rdat_r,   rdat_nxt;
  logic          call_r,   call_nxt;
  logic [3:0]    vec_r,    vec_nxt;
  logic          wake_r,   wake_nxt;
  logic [N-1:0]  events;
  logic [N-1:0]  pending;
  logic [3:0]    topIdx;
  logic          callFire;
  logic          busReq;
  logic          busWr;
  logic          pscTick;
  logic          serialEvt;

  itb_tick_if tick0 ();
  itb_tick_if tick1 ();

  // Index of the highest priority set bit
  function automatic logic [3:0] firstSet(input logic [N-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : firstSet

  // Merge write data into a register value by byte enables
  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = d[7:0];
    end
    if (sel[1]) begin
      res[15:8] = d[15:8];
    end
    return res;
  endfunction : laneMerge

  // ----------------------------------------------------------------
  // Prescaler and time base units
  // ----------------------------------------------------------------
  // Select the prescaled clock enable
  always_comb begin
    div_nxt = div_r + 2'h1;
    case (psc_r)
      itb_pkg::PSC_SYS:     pscTick = 1'b1;
      itb_pkg::PSC_SYS_DIV: pscTick = (div_r == 2'(itb_pkg::PSC_DIV - 1));
      default:              pscTick = subClkTick;
    endcase
  end

  assign tick0.tick      = pscTick;
  assign tick0.run       = time_base_0_control_r[itb_pkg::TB_RUN_BIT];
  assign tick0.periodSel = time_base_0_control_r[itb_pkg::TB_PER_LSB +: 3];
  assign tick1.tick      = pscTick;
  assign tick1.run       = time_base_1_control_r[itb_pkg::TB_RUN_BIT];
  assign tick1.periodSel = time_base_1_control_r[itb_pkg::TB_PER_LSB +: 3];

  itb_time_base u_tb0 (.clk(clk), .rst(rst), .tb(tick0.unit));
  itb_time_base u_tb1 (.clk(clk), .rst(rst), .tb(tick1.unit));

  // ----------------------------------------------------------------
  // Request events and arbitration
  // ----------------------------------------------------------------
  // Serial flag sources depend on the serial mode
  always_comb begin
    if (serialAsyncMode) begin
      serialEvt = asyncTxEmpty | asyncTxIdle | asyncRxAvail |
                  asyncOverrun | asyncAddrDetect | asyncRxWake;
    end else begin
      serialEvt = syncByteDone | syncAddrMatch | syncBusTimeout;
    end
  end

  // Gather event pulses by source index
  always_comb begin
    events                     = '0;
    events[itb_pkg::SRC_CONV]  = convDone;
    events[itb_pkg::SRC_TB0]   = tick0.overflow;
    events[itb_pkg::SRC_TB1]   = tick1.overflow;
    events[itb_pkg::SRC_SER]   = serialEvt;
    events[itb_pkg::SRC_LOW]   = lowSupply;
    events[itb_pkg::SRC_EE]    = eepromWriteDone;
    events[itb_pkg::SRC_PTMP]  = ptmPMatch;
    events[itb_pkg::SRC_PTMA]  = ptmAMatch;
    events[itb_pkg::SRC_STMP]  = stmPMatch;
    events[itb_pkg::SRC_STMA]  = stmAMatch;
  end

  // Enabled pending requests and the winner
  assign pending  = flags_r & enable_r;
  assign topIdx   = firstSet(pending);
  assign callFire = gie_r && (|pending) && !stackFull && !call_r;

  // ----------------------------------------------------------------
  // Bus slave and register state
  // ----------------------------------------------------------------
  assign busReq = wb_cyc_i && wb_stb_i && !ack_r;
  assign busWr  = busReq && wb_we_i;

  // Next values of registers, flags and core signals
  always_comb begin
    gie_nxt    = gie_r;
    enable_nxt = enable_r;
    flags_nxt  = flags_r;
    psc_nxt    = psc_r;
    time_base_0_control_nxt   = time_base_0_control_r;
    time_base_1_control_nxt   = time_base_1_control_r;
    ack_nxt    = busReq;
    rdat_nxt   = rdat_r;
    call_nxt   = callFire;
    vec_nxt    = callFire ? topIdx : vec_r;
    if (busWr) begin
      case (wb_adr_i)
        itb_pkg::OFS_CTRL:     if (wb_sel_i[0]) gie_nxt = wb_dat_i[itb_pkg::CTRL_GIE_BIT];
        itb_pkg::OFS_ENABLE:   enable_nxt = N'(laneMerge(16'(enable_r), wb_dat_i, wb_sel_i));
        itb_pkg::OFS_FLAGS:    flags_nxt  = N'(laneMerge(16'(flags_r), wb_dat_i, wb_sel_i));
        itb_pkg::OFS_PRESCALE: if (wb_sel_i[0]) psc_nxt = wb_dat_i[1:0];
        itb_pkg::OFS_TB0:      if (wb_sel_i[0]) time_base_0_control_nxt = wb_dat_i[7:0] & 8'h87;
        itb_pkg::OFS_TB1:      if (wb_sel_i[0]) time_base_1_control_nxt = wb_dat_i[7:0] & 8'h87;
        default:               ;
      endcase
    end
    if (retiStrobe) begin
      gie_nxt = 1'b1;
    end
    if (callFire) begin
      flags_nxt[topIdx] = 1'b0;
      gie_nxt           = 1'b0;
    end
    flags_nxt = flags_nxt | events;
    wake_nxt  = |(flags_nxt & ~flags_r);
    if (busReq && !wb_we_i) begin
      rdat_nxt = 32'h0000_0000;
      case (wb_adr_i)
        itb_pkg::OFS_CTRL:     rdat_nxt[itb_pkg::CTRL_GIE_BIT] = gie_r;
        itb_pkg::OFS_ENABLE:   rdat_nxt[N-1:0] = enable_r;
        itb_pkg::OFS_FLAGS:    rdat_nxt[N-1:0] = flags_r;
        itb_pkg::OFS_PRESCALE: rdat_nxt[1:0]   = psc_r;
        itb_pkg::OFS_TB0:      rdat_nxt[7:0]   = time_base_0_control_r;
        itb_pkg::OFS_TB1:      rdat_nxt[7:0]   = time_base_1_control_r;
        itb_pkg::OFS_STATUS: begin
          rdat_nxt[3:0]                    = topIdx;
          rdat_nxt[itb_pkg::STAT_ANY_BIT]  = |pending;
          rdat_nxt[itb_pkg::STAT_FULL_BIT] = stackFull;
        end
        default:               rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clk) begin
    if (rst) begin
      gie_r    <= itb_pkg::RST_GIE;
      enable_r <= itb_pkg::RST_ENABLE;
      flags_r  <= itb_pkg::RST_FLAGS;
      psc_r    <= itb_pkg::RST_PRESCALE;
      time_base_0_control_r   <= itb_pkg::RST_TBCTRL;
      time_base_1_control_r   <= itb_pkg::RST_TBCTRL;
      div_r    <= 2'h0;
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0000_0000;
      call_r   <= 1'b0;
      vec_r    <= 4'h0;
      wake_r   <= 1'b0;
    end else begin
      gie_r    <= gie_nxt;
      enable_r <= enable_nxt;
      flags_r  <= flags_nxt;
      psc_r    <= psc_nxt;
      time_base_0_control_r   <= time_base_0_control_nxt;
      time_base_1_control_r   <= time_base_1_control_nxt;
      div_r    <= div_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
      call_r   <= call_nxt;
      vec_r    <= vec_nxt;
      wake_r   <= wake_nxt;
    end
  end

  // Outputs toward bus and core
  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = rdat_r;
  assign irqCall   = call_r;
  assign irqVector = vec_r;
  assign pcPush    = call_r;
  assign wakeUp    = wake_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_call_cond;
    @(posedge clk) disable iff (rst)
      irqCall |-> $past(gie_r) && !$past(stackFull) && $past(pending[topIdx]);
  endproperty
  a_call_cond: assert property (p_call_cond) else $error("call without enables or with full stack");

  property p_call_gie;
    @(posedge clk) disable iff (rst) irqCall && !$past(retiStrobe) |-> !gie_r;
  endproperty
  a_call_gie: assert property (p_call_gie) else $error("global enable not cleared on call");

  property p_call_flag;
    @(posedge clk) disable iff (rst) irqCall && !$past(events[vec_r]) |-> !flags_r[vec_r];
  endproperty
  a_call_flag: assert property (p_call_flag) else $error("serviced flag not cleared");

  property p_prio;
    @(posedge clk) disable iff (rst)
      irqCall |-> ($past(pending) & ((10'h001 << vec_r) - 10'h001)) == '0;
  endproperty
  a_prio: assert property (p_prio) else $error("lower priority source served first");

  property p_events_latch;
    @(posedge clk) disable iff (rst) |events |=> (flags_r & $past(events)) == $past(events);
  endproperty
  a_events_latch: assert property (p_events_latch) else $error("request event lost");

  property p_flag_hold;
    @(posedge clk) disable iff (rst)
      !(busWr && wb_adr_i == itb_pkg::OFS_FLAGS) && !callFire |=> (flags_r & $past(flags_r)) == $past(flags_r);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("request flag dropped on its own");

  property p_wake;
    @(posedge clk) disable iff (rst) (|(flags_nxt & ~flags_r)) |=> wakeUp;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake-up on flag rise");

  property p_return_from_interrupt;
    @(posedge clk) disable iff (rst) retiStrobe && !callFire |=> gie_r;
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("interrupt return did not set global enable");

  property p_ret;
    @(posedge clk) disable iff (rst)
      retStrobe && !retiStrobe && !gie_r && !(busWr && wb_adr_i == itb_pkg::OFS_CTRL) |=> !gie_r;
  endproperty
  a_ret: assert property (p_ret) else $error("plain return changed global enable");

  property p_ack;
    @(posedge clk) disable iff (rst) busReq |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus acknowledge not one cycle after request");

  property p_serial;
    @(posedge clk) disable iff (rst) serialAsyncMode && asyncRxAvail |=> flags_r[itb_pkg::SRC_SER];
  endproperty
  a_serial: assert property (p_serial) else $error("async event did not set serial flag");

endmodule : itb_irq_ctrl

// ==== tb/itb_core_model.sv ====
/*
  Behavioural model of the processor core's return stack, facing the
  interrupt controller. Assumes pcPush is a one-cycle pulse on clk and that
  the bench asks for returns through retReq and retiReq.
*/
module itb_core_model #(
  parameter int DEPTH = 2
) (
  input  wire logic clk,        // System clock
  input  wire logic rst,        // Synchronous reset, active high
  input  wire logic pcPush,     // Program counter push from controller
  input  wire logic retReq,     // Bench asks for a plain return
  input  wire logic retiReq,    // Bench asks for an interrupt return
  output logic      stackFull,  // Return stack full
  output logic      retStrobe,  // Plain return executed
  output logic      retiStrobe  // Interrupt return executed
);
  timeunit 1ns;
  timeprecision 1ps;
  int depth;

  // ----------------------------------------------------------------
  // Stack depth
  // ----------------------------------------------------------------
  // Only pushes made by the controller grow the stack, no own calls
  // Program counter only; routines save their own registers
  always_ff @(posedge clk) begin
    if (rst) begin
      depth      <= 0;
      retStrobe  <= 1'b0;
      retiStrobe <= 1'b0;
    end else begin
      retStrobe  <= retReq && depth > 0;
      retiStrobe <= retiReq && depth > 0;
      depth      <= depth + (pcPush ? 1 : 0) - ((retStrobe || retiStrobe) ? 1 : 0);
    end
  end

  // Full when every level is taken
  assign stackFull = depth >= DEPTH;
endmodule : itb_core_model

// ==== tb/itb_irq_ctrl_tb.sv ====
/*
  Self-checking bench of the interrupt controller: registers, events, calls,
  returns and time base periods. Assumes the design and the core model.
*/
module itb_irq_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, mode = 0, retReq = 0, retiReq = 0;
  logic        ack, full, retS, retiS, call, push, wake;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0, vec, lastVec;
  logic [31:0] dat = 0, rdat, q;
  logic [16:0] ev = 0;
  int          failures = 0, samplesChecked = 0, callCnt = 0, pushCnt = 0, wakeCnt = 0, w;
  int          srcOf[16] = '{0, 3, 3, 3, 3, 3, 3, 3, 3, 3, 4, 5, 6, 7, 8, 9};

  always #5 clk = ~clk;

  // Count calls, pushes and wake pulses
  always @(posedge clk) begin
    if (call === 1'b1) begin callCnt++; lastVec = vec; end
    if (push === 1'b1) pushCnt++;
    if (wake === 1'b1) wakeCnt++;
  end

  itb_irq_ctrl itb_irq_ctrl_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .convDone(ev[0]),
    .serialAsyncMode(mode), .syncByteDone(ev[1]), .syncAddrMatch(ev[2]), .syncBusTimeout(ev[3]),
    .asyncTxEmpty(ev[4]), .asyncTxIdle(ev[5]), .asyncRxAvail(ev[6]), .asyncOverrun(ev[7]),
    .asyncAddrDetect(ev[8]), .asyncRxWake(ev[9]), .lowSupply(ev[10]), .eepromWriteDone(ev[11]),
    .ptmPMatch(ev[12]), .ptmAMatch(ev[13]), .stmPMatch(ev[14]), .stmAMatch(ev[15]), .subClkTick(ev[16]),
    .stackFull(full), .retStrobe(retS), .retiStrobe(retiS), .irqCall(call), .irqVector(vec),
    .pcPush(push), .wakeUp(wake));

  itb_core_model itb_core_model_inst (.clk(clk), .rst(rst), .pcPush(push), .retReq(retReq),
    .retiReq(retiReq), .stackFull(full), .retStrobe(retS), .retiStrobe(retiS));

  task report_and_stop;
    $display("Checked %0d, mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin failures++; $display("Error %s expected %h seen %h", nm, e, g); end
  endtask : chk

  // One classic Wishbone cycle, held until ack
  task wb(input logic w1, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w1; adr <= a; dat <= d; sel <= 4'h3;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 0; stb <= 0;
    if (ack !== 1'b1) begin failures++; report_and_stop(); end
  endtask : wb

  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd

  task pulse(input logic [16:0] m);
    @(posedge clk); ev <= m;
    @(posedge clk); ev <= 0;
  endtask : pulse

  task waitCall(input int n, input logic [3:0] v);
    for (int k = 0; k < 30 && callCnt < n; k++) @(posedge clk);
    if (callCnt < n) begin failures++; report_and_stop(); end
    chk("vector", v, lastVec);
  endtask : waitCall

  task t_regs;
    for (int a = 0; a <= 8'h1c; a += 4) rd(a[7:0], 0);
    wb(1, 8'h1c, 32'hffff); rd(8'h1c, 0);
    wb(1, itb_pkg::OFS_PRESCALE, 32'hff); rd(itb_pkg::OFS_PRESCALE, 32'h3);
    wb(1, itb_pkg::OFS_TB0, 32'h0f); rd(itb_pkg::OFS_TB0, 32'h07);
    wb(1, itb_pkg::OFS_TB0, 0); wb(1, itb_pkg::OFS_PRESCALE, 0);
    $display("Registers done");
  endtask : t_regs

  task t_events;
    for (int i = 0; i < 16; i++) begin
      mode <= (i >= 4 && i <= 9);
      w = wakeCnt;
      pulse(17'h1 << i);
      rd(itb_pkg::OFS_FLAGS, 32'h1 << srcOf[i]);
      chk("wake", w + 1, wakeCnt);
      wb(1, itb_pkg::OFS_FLAGS, 0);
    end
    wb(1, itb_pkg::OFS_FLAGS, 32'h10);
    @(posedge clk);  // Let the wake of the preset write be counted
    w = wakeCnt;
    pulse(17'h400);
    chk("preset wake", w, wakeCnt);
    wb(1, itb_pkg::OFS_FLAGS, 0);
    $display("Events done");
  endtask : t_events

  task t_calls;
    wb(1, itb_pkg::OFS_ENABLE, 32'h31);
    pulse(17'hc00);
    rd(itb_pkg::OFS_FLAGS, 32'h30);
    wb(1, itb_pkg::OFS_CTRL, 1);
    waitCall(1, 4);
    rd(itb_pkg::OFS_CTRL, 0);
    rd(itb_pkg::OFS_FLAGS, 32'h20);
    wb(1, itb_pkg::OFS_CTRL, 1);
    waitCall(2, 5);
    pulse(17'h1);
    wb(1, itb_pkg::OFS_CTRL, 1);
    repeat (20) @(posedge clk);
    chk("calls while full", 2, callCnt);
    rd(itb_pkg::OFS_STATUS, 32'h30);
    wb(1, itb_pkg::OFS_CTRL, 0);
    @(posedge clk) retiReq <= 1;
    @(posedge clk) retiReq <= 0;
    waitCall(3, 0);
    chk("pushes", 3, pushCnt);
    @(posedge clk) retReq <= 1;
    @(posedge clk) retReq <= 0;
    repeat (3) @(posedge clk);
    rd(itb_pkg::OFS_CTRL, 0);
    wb(1, itb_pkg::OFS_ENABLE, 0);
    $display("Calls done");
  endtask : t_calls

  // Start one unit and time the wake caused by its flag
  task period(input logic [7:0] a, input logic [1:0] ps, input logic [7:0] v, input int lo, input int hi, input int src);
    int n;
    wb(1, itb_pkg::OFS_PRESCALE, ps);
    w = wakeCnt;
    wb(1, a, v);
    n = 0;
    while (wakeCnt == w && n < hi) begin @(posedge clk); n++; end
    if (lo == 0) chk("idle wake", w, wakeCnt);
    else if (wakeCnt == w) begin failures++; report_and_stop(); end
    else chk("period", 1, n >= lo && n <= hi);
    if (lo != 0) rd(itb_pkg::OFS_FLAGS, 32'h1 << src);
    wb(1, a, 0);
    wb(1, itb_pkg::OFS_FLAGS, 0);
  endtask : period

  task t_tbase;
    period(itb_pkg::OFS_TB0, 2'h0, 8'h80, 254, 264, 1);
    period(itb_pkg::OFS_TB1, 2'h0, 8'h81, 510, 520, 2);
    period(itb_pkg::OFS_TB0, 2'h1, 8'h80, 1020, 1036, 1);
    period(itb_pkg::OFS_TB0, 2'h2, 8'h80, 0, 600, 1);
    period(itb_pkg::OFS_TB1, 2'h0, 8'h07, 0, 600, 2);
    $display("Time base done");
  endtask : t_tbase

  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs();
    t_events();
    t_calls();
    t_tbase();
    report_and_stop();
  end
endmodule : itb_irq_ctrl_tb
